// ==== design/dsw_cfg.svh ====
/*
 * Bit positions, widths and reset values of the drive status word.
 * Assumes inclusion by bare name from the dsw package and modules.
 */
`ifndef DSW_CFG_SVH
`define DSW_CFG_SVH

// ============================================================
// word geometry
`define DSW_WORD_W 32
`define DSW_FB_W 16
`define DSW_USER_W 4

// ============================================================
// bit positions
`define DSW_BIT_READY 0
`define DSW_BIT_RUN_ENABLE 1
`define DSW_BIT_MODULATING 3
`define DSW_BIT_SPEED_NULL 4
`define DSW_BIT_RAMP_UP 5
`define DSW_BIT_RAMP_DOWN 6
`define DSW_BIT_ON_TARGET 7
`define DSW_BIT_CONSTRAINED 8
`define DSW_BIT_THRESHOLD 9
`define DSW_BIT_REF_BACKWARD 10
`define DSW_BIT_ACT_BACKWARD 11
`define DSW_BIT_KEYPAD_OWNS 12
`define DSW_BIT_BUS_OWNS 13
`define DSW_BIT_SECOND_LOC 14
`define DSW_BIT_TRIP 15
`define DSW_BIT_WARN 16
`define DSW_BIT_USER_LO 22
`define DSW_BIT_CTL_REQUEST 26

// ============================================================
// reset values
`define DSW_WORD_RESET 32'h0000_0000
`define DSW_FB_RESET 16'h0000
`define DSW_USER_RESET 4'h0

`endif

// ==== design/dsw_pkg.sv ====
/*
 * Types and helpers shared by the drive status word block.
 * Assumes dsw_cfg.svh is on the include path.
 */
`include "dsw_cfg.svh"

package dsw_pkg;

  // ============================================================
  // types
  typedef logic [`DSW_WORD_W-1:0] dsw_word_t;
  typedef logic [`DSW_FB_W-1:0] dsw_fb_word_t;
  typedef logic [`DSW_USER_W-1:0] dsw_user_t;

  // ============================================================
  // helpers
  // lower half of the drive word, bit for bit
  function automatic dsw_fb_word_t dsw_fb_half(input dsw_word_t word);
    dsw_fb_half = word[`DSW_FB_W-1:0];
  endfunction : dsw_fb_half

endpackage : dsw_pkg

// ==== design/dsw_word_pack.sv ====
/*
 * Packs the sampled drive conditions into the 32-bit status word.
 * Assumes all inputs come from registers of the same clock domain.
 */
`timescale 1ns/1ps
`default_nettype none
`include "dsw_cfg.svh"

module dsw_word_pack
  import dsw_pkg::*;
(
  input wire logic i_ready,
  input wire logic i_run_enable,
  input wire logic i_modulating,
  input wire logic i_speed_null,
  input wire logic i_ramp_up,
  input wire logic i_ramp_down,
  input wire logic i_on_target,
  input wire logic i_constrained,
  input wire logic i_threshold_exceeded,
  input wire logic i_ref_backward,
  input wire logic i_act_backward,
  input wire logic i_keypad_owns,
  input wire logic i_bus_owns,
  input wire logic i_second_location,
  input wire logic i_trip,
  input wire logic i_warn,
  input wire dsw_pkg::dsw_user_t i_user_bits,
  input wire logic i_ctl_request,
  output dsw_pkg::dsw_word_t o_word
);
  import dsw_pkg::*;

  // ============================================================
  // packing
  always_comb begin
    // reserved positions 2, 17..21, 27..31 stay zero
    o_word = `DSW_WORD_RESET;
    o_word[`DSW_BIT_READY] = i_ready;
    o_word[`DSW_BIT_RUN_ENABLE] = i_run_enable;
    o_word[`DSW_BIT_MODULATING] = i_modulating;
    o_word[`DSW_BIT_SPEED_NULL] = i_speed_null;
    o_word[`DSW_BIT_RAMP_UP] = i_ramp_up;
    o_word[`DSW_BIT_RAMP_DOWN] = i_ramp_down;
    o_word[`DSW_BIT_ON_TARGET] = i_on_target;
    o_word[`DSW_BIT_CONSTRAINED] = i_constrained;
    o_word[`DSW_BIT_THRESHOLD] = i_threshold_exceeded;
    o_word[`DSW_BIT_REF_BACKWARD] = i_ref_backward;
    o_word[`DSW_BIT_ACT_BACKWARD] = i_act_backward;
    o_word[`DSW_BIT_KEYPAD_OWNS] = i_keypad_owns;
    o_word[`DSW_BIT_BUS_OWNS] = i_bus_owns;
    o_word[`DSW_BIT_SECOND_LOC] = i_second_location;
    o_word[`DSW_BIT_TRIP] = i_trip;
    o_word[`DSW_BIT_WARN] = i_warn;
    o_word[`DSW_BIT_USER_LO +: `DSW_USER_W] = i_user_bits;
    o_word[`DSW_BIT_CTL_REQUEST] = i_ctl_request;
  end

endmodule : dsw_word_pack

`default_nettype wire

// ==== design/dsw_change_detect.sv ====
/*
 * Registers the fieldbus half and reports which bits changed.
 * Assumes a synchronous active-low reset on the shared clock.
 */
`timescale 1ns/1ps
`default_nettype none
`include "dsw_cfg.svh"

module dsw_change_detect
  import dsw_pkg::*;
(
  input wire logic i_core_clk,
  input wire logic i_reset_n,
  input wire dsw_pkg::dsw_fb_word_t i_fb_word,
  output dsw_pkg::dsw_fb_word_t o_fb_word,
  output dsw_pkg::dsw_fb_word_t o_changed_bits,
  output logic o_changed
);
  import dsw_pkg::*;

  dsw_fb_word_t diff_nxt;

  assign diff_nxt = i_fb_word ^ o_fb_word;

  // ============================================================
  // fieldbus copy and change report
  always_ff @(posedge i_core_clk) begin
    if (!i_reset_n) begin
      o_fb_word <= `DSW_FB_RESET;
      o_changed_bits <= `DSW_FB_RESET;
      o_changed <= 1'b0;
    end else begin
      o_fb_word <= i_fb_word;
      o_changed_bits <= diff_nxt;
      o_changed <= |diff_nxt;
    end
  end

endmodule : dsw_change_detect

`default_nettype wire

// ==== design/dsw_status_word.sv ====
/*
 * Drive status word as published to a fieldbus master.
 * Samples drive conditions each clock, builds the 32-bit internal word
 * and the 16-bit fieldbus word, and pulses when the fieldbus word moves.
 * Assumes all condition inputs are synchronous to i_core_clk.
 */
`timescale 1ns/1ps
`default_nettype none
`include "dsw_cfg.svh"

module dsw_status_word
  import dsw_pkg::*;
(
  input wire logic i_core_clk,
  input wire logic i_reset_n,
  input wire logic i_ready,
  input wire logic i_run_enable,
  input wire logic i_modulating,
  input wire logic i_speed_null,
  input wire logic i_ramp_up,
  input wire logic i_ramp_down,
  input wire logic i_on_target,
  input wire logic i_constrained,
  input wire logic i_threshold_exceeded,
  input wire logic i_ref_backward,
  input wire logic i_act_backward,
  input wire logic i_keypad_owns,
  input wire logic i_bus_owns,
  input wire logic i_second_location,
  input wire logic i_trip,
  input wire logic i_warn,
  input wire dsw_pkg::dsw_user_t i_user_bits,
  input wire logic i_ctl_request,
  output dsw_pkg::dsw_word_t o_drive_status_word,
  output dsw_pkg::dsw_fb_word_t o_fieldbus_status_word,
  output dsw_pkg::dsw_fb_word_t o_fieldbus_changed_bits,
  output logic o_fieldbus_changed
);
  import dsw_pkg::*;

  // ============================================================
  // sampled drive conditions
  logic ready_r;
  logic run_enable_r;
  logic modulating_flag_r;
  logic speed_null_flag_r;
  logic ramp_up_flag_r;
  logic ramp_down_flag_r;
  logic on_target_flag_r;
  logic constrained_flag_r;
  logic threshold_exceeded_flag_r;
  logic ref_backward_flag_r;
  logic act_backward_flag_r;
  logic keypad_owns_flag_r;
  logic bus_owns_flag_r;
  logic second_location_flag_r;
  logic trip_flag_r;
  logic warn_flag_r;
  dsw_user_t user_bits_r;
  logic ctl_request_flag_r;

  dsw_word_t word_nxt;
  dsw_word_t drive_profile_status_word_r;
  dsw_fb_word_t fb_word_nxt;

  // ============================================================
  // readiness and run enable
  always_ff @(posedge i_core_clk) begin
    if (!i_reset_n) begin
      ready_r <= 1'b0;
      run_enable_r <= 1'b0;
    end else begin
      ready_r <= i_ready;
      run_enable_r <= i_run_enable;
    end
  end

  // ============================================================
  // motion state
  always_ff @(posedge i_core_clk) begin
    if (!i_reset_n) begin
      modulating_flag_r <= 1'b0;
      speed_null_flag_r <= 1'b0;
      ramp_up_flag_r <= 1'b0;
      ramp_down_flag_r <= 1'b0;
      on_target_flag_r <= 1'b0;
      constrained_flag_r <= 1'b0;
      threshold_exceeded_flag_r <= 1'b0;
    end else begin
      modulating_flag_r <= i_modulating;
      speed_null_flag_r <= i_speed_null;
      ramp_up_flag_r <= i_ramp_up;
      ramp_down_flag_r <= i_ramp_down;
      on_target_flag_r <= i_on_target;
      constrained_flag_r <= i_constrained;
      threshold_exceeded_flag_r <= i_threshold_exceeded;
    end
  end

  // ============================================================
  // direction
  always_ff @(posedge i_core_clk) begin
    if (!i_reset_n) begin
      ref_backward_flag_r <= 1'b0;
      act_backward_flag_r <= 1'b0;
    end else begin
      ref_backward_flag_r <= i_ref_backward;
      act_backward_flag_r <= i_act_backward;
    end
  end

  // ============================================================
  // control location and ownership
  always_ff @(posedge i_core_clk) begin
    if (!i_reset_n) begin
      keypad_owns_flag_r <= 1'b0;
      bus_owns_flag_r <= 1'b0;
      second_location_flag_r <= 1'b0;
      ctl_request_flag_r <= 1'b0;
    end else begin
      keypad_owns_flag_r <= i_keypad_owns;
      bus_owns_flag_r <= i_bus_owns;
      second_location_flag_r <= i_second_location;
      ctl_request_flag_r <= i_ctl_request;
    end
  end

  // ============================================================
  // health
  always_ff @(posedge i_core_clk) begin
    if (!i_reset_n) begin
      trip_flag_r <= 1'b0;
      warn_flag_r <= 1'b0;
    end else begin
      trip_flag_r <= i_trip;
      warn_flag_r <= i_warn;
    end
  end

  // ============================================================
  // application user bits
  always_ff @(posedge i_core_clk) begin
    if (!i_reset_n) begin
      user_bits_r <= `DSW_USER_RESET;
    end else begin
      user_bits_r <= i_user_bits;
    end
  end

  // ============================================================
  // word assembly
  dsw_word_pack u_pack (
    .i_ready(ready_r),
    .i_run_enable(run_enable_r),
    .i_modulating(modulating_flag_r),
    .i_speed_null(speed_null_flag_r),
    .i_ramp_up(ramp_up_flag_r),
    .i_ramp_down(ramp_down_flag_r),
    .i_on_target(on_target_flag_r),
    .i_constrained(constrained_flag_r),
    .i_threshold_exceeded(threshold_exceeded_flag_r),
    .i_ref_backward(ref_backward_flag_r),
    .i_act_backward(act_backward_flag_r),
    .i_keypad_owns(keypad_owns_flag_r),
    .i_bus_owns(bus_owns_flag_r),
    .i_second_location(second_location_flag_r),
    .i_trip(trip_flag_r),
    .i_warn(warn_flag_r),
    .i_user_bits(user_bits_r),
    .i_ctl_request(ctl_request_flag_r),
    .o_word(word_nxt)
  );

  // ============================================================
  // internal 32-bit word
  always_ff @(posedge i_core_clk) begin
    if (!i_reset_n) begin
      drive_profile_status_word_r <= `DSW_WORD_RESET;
    end else begin
      drive_profile_status_word_r <= word_nxt;
    end
  end

  assign o_drive_status_word = drive_profile_status_word_r;

  // ============================================================
  // fieldbus half
  // only bits 15..0 are taken; warn, user and request bits stay internal
  assign fb_word_nxt = dsw_fb_half(word_nxt);

  dsw_change_detect u_change (
    .i_core_clk(i_core_clk),
    .i_reset_n(i_reset_n),
    .i_fb_word(fb_word_nxt),
    .o_fb_word(o_fieldbus_status_word),
    .o_changed_bits(o_fieldbus_changed_bits),
    .o_changed(o_fieldbus_changed)
  );

endmodule : dsw_status_word

`default_nettype wire

// ==== bench/dsw_bus_master.sv ====
/* Fieldbus master model that keeps the last published status word.
   Assumes the drive clock and synchronous active-low reset. */
`timescale 1ns/1ps
`default_nettype none
module dsw_bus_master (
  input wire logic i_core_clk,
  input wire logic i_reset_n,
  input wire dsw_pkg::dsw_fb_word_t i_word,
  input wire logic i_changed,
  output dsw_pkg::dsw_fb_word_t o_last
);
  import dsw_pkg::*;
  // picks up the word only when the drive flags a change
  always_ff @(posedge i_core_clk) begin
    if (!i_reset_n) o_last <= 16'h0000;
    else if (i_changed) o_last <= i_word;
  end
endmodule : dsw_bus_master
`default_nettype wire

// ==== bench/dsw_status_word_sva.sv ====
/* Checker of both status words and the change report.
   Assumes a two-cycle latency and a synchronous active-low reset. */
`timescale 1ns/1ps
`default_nettype none
module dsw_status_word_sva (
  input wire logic i_core_clk,
  input wire logic i_reset_n,
  input wire logic i_ready,
  input wire logic i_run_enable,
  input wire logic i_modulating,
  input wire logic i_speed_null,
  input wire logic i_ramp_up,
  input wire logic i_ramp_down,
  input wire logic i_on_target,
  input wire logic i_constrained,
  input wire logic i_threshold_exceeded,
  input wire logic i_ref_backward,
  input wire logic i_act_backward,
  input wire logic i_keypad_owns,
  input wire logic i_bus_owns,
  input wire logic i_second_location,
  input wire logic i_trip,
  input wire logic i_warn,
  input wire dsw_pkg::dsw_user_t i_user_bits,
  input wire logic i_ctl_request,
  input wire dsw_pkg::dsw_word_t o_drive_status_word,
  input wire dsw_pkg::dsw_fb_word_t o_fieldbus_status_word,
  input wire dsw_pkg::dsw_fb_word_t o_fieldbus_changed_bits,
  input wire logic o_fieldbus_changed
);
  import dsw_pkg::*;
  // ============================================================
  // expected word from the raw conditions
  dsw_word_t x;
  dsw_word_t w;
  dsw_fb_word_t f;
  assign w = o_drive_status_word;
  assign f = o_fieldbus_status_word;
  assign x = {5'h00, i_ctl_request, i_user_bits, 5'h00, i_warn, i_trip,
    i_second_location, i_bus_owns, i_keypad_owns, i_act_backward,
    i_ref_backward, i_threshold_exceeded, i_constrained, i_on_target,
    i_ramp_down, i_ramp_up, i_speed_null, i_modulating, 1'b0,
    i_run_enable, i_ready};
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_reset_n);
  // both pipeline stages have left reset
  sequence s_live; $past(i_reset_n) && $past(i_reset_n, 2); endsequence
  property p_copy; w[15:0] == f; endproperty
  a_copy: assert property (p_copy)
    else $error("fieldbus word differs from low half");
  property p_change; s_live |-> o_fieldbus_changed_bits == (f ^ $past(f))
    && o_fieldbus_changed == (o_fieldbus_changed_bits != 16'h0);
  endproperty
  a_change: assert property (p_change)
    else $error("change report wrong");
  property p_ctl; s_live |-> w[1:0] == $past(x[1:0], 2); endproperty
  a_ctl: assert property (p_ctl)
    else $error("ready bits wrong");
  property p_motion; s_live |-> w[7:3] == $past(x[7:3], 2); endproperty
  a_motion: assert property (p_motion)
    else $error("motion bits wrong");
  property p_limit; s_live |-> w[9:8] == $past(x[9:8], 2); endproperty
  a_limit: assert property (p_limit)
    else $error("limit bits wrong");
  property p_dir; s_live |-> w[11:10] == $past(x[11:10], 2); endproperty
  a_dir: assert property (p_dir)
    else $error("direction bits wrong");
  property p_loc; s_live |-> w[14:12] == $past(x[14:12], 2); endproperty
  a_loc: assert property (p_loc)
    else $error("location bits wrong");
  property p_fault; s_live |-> w[16:15] == $past(x[16:15], 2); endproperty
  a_fault: assert property (p_fault)
    else $error("fault bits wrong");
  property p_user; s_live |-> w[25:22] == $past(x[25:22], 2); endproperty
  a_user: assert property (p_user)
    else $error("user bits wrong");
  property p_req; s_live |-> w[26] == $past(x[26], 2); endproperty
  a_req: assert property (p_req)
    else $error("request bit wrong");
  property p_rsvd; (w & 32'hf83e_0004) == 32'h0; endproperty
  a_rsvd: assert property (p_rsvd)
    else $error("reserved bit set");
endmodule : dsw_status_word_sva
bind dsw_status_word dsw_status_word_sva i_dsw_status_word_sva (.*);
`default_nettype wire

// ==== bench/testbench.sv ====
/* Bench that drives drive conditions and checks words and change report.
   Assumes a two-cycle latency from condition to word. */
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import dsw_pkg::*;
  localparam dsw_word_t LIVE = 32'h07c1_fffb;
  logic i_core_clk = 1'b0;
  logic i_reset_n = 1'b0;
  dsw_word_t stim = 32'h0;
  dsw_word_t p1 = 32'h0;
  dsw_word_t p2 = 32'h0;
  dsw_fb_word_t pf = 16'h0;
  dsw_word_t dw;
  dsw_fb_word_t fw, cb, mw;
  logic ch;
  int fail_count = 0;
  int comparisons = 0;
  always #20 i_core_clk = ~i_core_clk;
  dsw_status_word i_dsw_status_word (
    .i_core_clk(i_core_clk), .i_reset_n(i_reset_n),
    .i_ready(stim[0]), .i_run_enable(stim[1]), .i_modulating(stim[3]),
    .i_speed_null(stim[4]), .i_ramp_up(stim[5]), .i_ramp_down(stim[6]),
    .i_on_target(stim[7]), .i_constrained(stim[8]),
    .i_threshold_exceeded(stim[9]), .i_ref_backward(stim[10]),
    .i_act_backward(stim[11]), .i_keypad_owns(stim[12]),
    .i_bus_owns(stim[13]), .i_second_location(stim[14]),
    .i_trip(stim[15]), .i_warn(stim[16]), .i_user_bits(stim[25:22]),
    .i_ctl_request(stim[26]), .o_drive_status_word(dw),
    .o_fieldbus_status_word(fw), .o_fieldbus_changed_bits(cb),
    .o_fieldbus_changed(ch));
  dsw_bus_master i_dsw_bus_master (.i_core_clk(i_core_clk),
    .i_reset_n(i_reset_n), .i_word(fw), .i_changed(ch), .o_last(mw));
  task automatic fail(input string msg);
    fail_count++;
    $display("[ERR] %0t %s", $time, msg);
  endtask : fail
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : summarize
  // applies one condition word and checks the one from two edges back
  task automatic step(input dsw_word_t v);
    dsw_word_t e;
    @(posedge i_core_clk);
    stim <= v;
    #1;
    e = p2 & LIVE;
    comparisons += 4;
    if (dw !== e) fail("drive word");
    if (fw !== e[15:0]) fail("fieldbus word");
    if (cb !== (e[15:0] ^ pf) || ch !== (e[15:0] != pf)) fail("change");
    if (mw !== pf) fail("master copy");
    pf = e[15:0];
    p2 = p1;
    p1 = v;
  endtask : step
  task automatic walk(input int lo, input int hi);
    for (int k = lo; k <= hi; k++) begin
      step(32'h1 << k);
      step(32'h0);
    end
  endtask : walk
  task automatic mid_reset(input dsw_word_t v);
    @(posedge i_core_clk);
    i_reset_n <= 1'b0;
    stim <= v;
    repeat (2) @(posedge i_core_clk);
    #1;
    comparisons++;
    if (dw !== 32'h0 || fw !== 16'h0 || ch !== 1'b0) fail("reset");
    @(posedge i_core_clk);
    i_reset_n <= 1'b1;
    p1 = v;
    p2 = 32'h0;
    pf = 16'h0;
  endtask : mid_reset
  initial begin
    repeat (12) @(posedge i_core_clk);
    i_reset_n <= 1'b1;
    step(32'h0);
    walk(0, 4);
    walk(5, 9);
    walk(10, 14);
    walk(15, 21);
    walk(22, 31);
    step(32'hffff_ffff);
    step(32'h5555_aaaa);
    step(32'haaaa_5555);
    step(32'hffff_0000);
    repeat (3) step(32'h0);
    mid_reset(32'h0000_8001);
    step(32'h0000_8001);
    repeat (3) step(32'h0);
    summarize();
  end
  initial begin
    #80000;
    fail("watchdog");
    summarize();
  end
endmodule : testbench
`default_nettype wire
